// ---- logic/dioce_regs.vh ----
// Constants for the digital input/output counter and encoder block
// What this block does
// (RULE_01) Eight lines: six bidirectional, two input only
// (RULE_02) Lines one to eight, line one is LSB
// (RULE_03) Sampling starts on run, at configured rate
// (RULE_04) Run captures inputs as filter initial state
// (RULE_05) Counters optionally filtered; encoders never filtered
// (RULE_06) Filter is up/down counter, per-line threshold
// (RULE_07) Count up on one, down on zero, saturating
// (RULE_08) Output changes only at zero or threshold
// (RULE_09) Threshold range is 1 to 255
// (RULE_10) 32-bit counters count both or rising edges
// (RULE_11) Per-input inversion allows falling-edge counting
// (RULE_12) Alarm when count exceeds limit 1..255; the code alarms when the count since the last alarm reaches the limit
// (RULE_13) Time stamp each increment, reported on read
// (RULE_14) Encoders use odd-starting adjacent line pairs
// (RULE_15) Encoder 32-bit up/down; inversion swaps direction
// (RULE_16) Two encoder alarm thresholds, one per direction
// (RULE_17) Lines allocate to encoders, counters, or mix
// (RULE_18) Outputs switched by command; pulse command pulses
// (RULE_19) Count valid Gray steps, ignore double transitions
// (RULE_20) Pulse commands ignored while stopped
`ifndef DIOCE_REGS_VH
`define DIOCE_REGS_VH

// ----------------------------------------------------------------
// Register offsets (word addresses)
// ----------------------------------------------------------------
`define DIOCE_CTRL 8'h00
`define DIOCE_STATUS 8'h01
`define DIOCE_RATE 8'h02
`define DIOCE_OUT_EN 8'h03
`define DIOCE_OUT_VAL 8'h04
`define DIOCE_PULSE 8'h05
`define DIOCE_PULSE_LEN 8'h06
`define DIOCE_FILT_EN 8'h07
`define DIOCE_INVERT 8'h08
`define DIOCE_BOTH_EDGE 8'h09
`define DIOCE_ENC_EN 8'h0a
`define DIOCE_ALARM 8'h0b
`define DIOCE_TIME 8'h0c
`define DIOCE_PINS 8'h0d
// Per-line banks: base plus line index 0..7
`define DIOCE_THR_BASE 8'h10
`define DIOCE_LIM_BASE 8'h18
`define DIOCE_CNT_BASE 8'h20
`define DIOCE_STAMP_BASE 8'h28

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DIOCE_CTRL_RUN 0
`define DIOCE_CTRL_STOP 1
`define DIOCE_RATE_RST 32'h0001_86a0
`define DIOCE_THR_RST 8'h01
`define DIOCE_LIM_RST 8'h01
`define DIOCE_PULSE_LEN_RST 32'h0000_0064

`endif

// ---- logic/dioce_top.v ----
// Digital input/output counter and shaft encoder block
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "dioce_regs.vh"

module dioce_top #(
  parameter NLINES = 8,
  parameter NOUT = 6
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Digital lines (line one is bit 0)
  input wire [NLINES-1:0] line_in,
  output wire [NLINES-1:0] line_out,
  output wire [NLINES-1:0] line_oe,
  // Host alarm and run messages
  output reg alarm_pulse,
  output reg [3:0] alarm_src,
  output reg run_done
);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  reg running_ff; // Run state
  reg [31:0] rate_ff; // Sample divider, in core clocks
  reg [31:0] div_ff; // Divider count
  reg [31:0] time_ff; // Free time base in samples
  reg [NOUT-1:0] out_en_ff; // Output enables
  reg [NOUT-1:0] out_val_ff; // Steady output levels
  reg [NOUT-1:0] pulse_mask_ff; // Lines currently pulsed
  reg [31:0] pulse_len_ff; // Pulse length in core clocks
  reg [31:0] pulse_cnt_ff; // Pulse remaining
  reg [NLINES-1:0] filt_en_ff; // Filter enable per line
  reg [NLINES-1:0] inv_ff; // Inversion per line
  reg [NLINES-1:0] both_ff; // Both-edge mode per line
  reg [3:0] enc_en_ff; // Encoder on pair
  reg [NLINES-1:0] alarm_ff; // Sticky alarm flags, bit per line
  reg [7:0] thr_ff [0:NLINES-1]; // Filter thresholds
  reg [7:0] lim_ff [0:NLINES-1]; // Alarm limits
  reg [7:0] fcnt_ff [0:NLINES-1]; // Filter counts
  reg [NLINES-1:0] fout_ff; // Filter outputs
  reg [NLINES-1:0] prev_ff; // Previous counter-input level
  reg [31:0] cnt_ff [0:NLINES-1]; // Counters (encoder uses even slot)
  reg [31:0] stamp_ff [0:NLINES-1]; // Time of last count
  reg [31:0] base_ff [0:NLINES-1]; // Count at last alarm
  reg start_ff; // One-cycle pulse after run

  wire sample_en; // One-cycle sample tick
  wire [NLINES-1:0] inv_in; // Raw inputs after per-line inversion
  wire wr_lines; // Write to a per-line bank
  wire [2:0] widx; // Per-line index
  wire [NLINES-1:0] dn_hit; // Down alarm due, decided on each pair's even slot
  integer i;

  assign sample_en = running_ff && (div_ff == 32'h0000_0000); // RULE_03
  assign inv_in = line_in ^ inv_ff; // RULE_11
  assign widx = reg_addr[2:0];
  assign wr_lines = reg_wr && (reg_addr[7:4] != 4'h0);

  // ----------------------------------------------------------------
  // Outputs: open drain style, lines 2..7 can drive
  // ----------------------------------------------------------------
  // Line 1 and line 8 are input only, so their enables stay low
  assign line_oe = {1'b0, out_en_ff, 1'b0}; // RULE_01
  assign line_out = {1'b0, out_val_ff ^ pulse_mask_ff, 1'b0}; // RULE_18

  // Decode whether a line belongs to an active encoder pair
  function enc_line;
    input [3:0] en;
    input [2:0] idx;
    begin
      enc_line = en[idx[2:1]]; // RULE_14
    end
  endfunction

  // ----------------------------------------------------------------
  // Control, sample divider and register writes
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      running_ff <= 1'b0;
      rate_ff <= `DIOCE_RATE_RST;
      div_ff <= 32'h0000_0000;
      time_ff <= 32'h0000_0000;
      out_en_ff <= {NOUT{1'b0}};
      out_val_ff <= {NOUT{1'b0}};
      pulse_mask_ff <= {NOUT{1'b0}};
      pulse_len_ff <= `DIOCE_PULSE_LEN_RST;
      pulse_cnt_ff <= 32'h0000_0000;
      filt_en_ff <= {NLINES{1'b0}};
      inv_ff <= {NLINES{1'b0}};
      both_ff <= {NLINES{1'b0}};
      enc_en_ff <= 4'h0;
      start_ff <= 1'b0;
      run_done <= 1'b0;
    end
    else
    begin
      start_ff <= 1'b0;
      run_done <= start_ff;
      // Divider reloads each tick; stopped it holds at zero
      if (!running_ff)
        div_ff <= 32'h0000_0000;
      else if (div_ff == 32'h0000_0000)
        div_ff <= rate_ff - 32'h0000_0001;
      else
        div_ff <= div_ff - 32'h0000_0001;
      if (sample_en)
        time_ff <= time_ff + 32'h0000_0001;
      // Pulse timer restores the steady level when it runs out
      if (pulse_cnt_ff != 32'h0000_0000)
        pulse_cnt_ff <= pulse_cnt_ff - 32'h0000_0001;
      else
        pulse_mask_ff <= {NOUT{1'b0}};
      if (reg_wr)
      begin
        case (reg_addr)
          `DIOCE_CTRL:
          begin
            if (reg_wdata[`DIOCE_CTRL_RUN])
            begin
              running_ff <= 1'b1; // RULE_03
              start_ff <= 1'b1;
            end
            else if (reg_wdata[`DIOCE_CTRL_STOP])
            begin
              running_ff <= 1'b0;
              pulse_mask_ff <= {NOUT{1'b0}};
            end
          end
          `DIOCE_RATE: rate_ff <= (reg_wdata == 32'h0) ? 32'h0000_0001 : reg_wdata;
          `DIOCE_OUT_EN: out_en_ff <= reg_wdata[NOUT-1:0];
          `DIOCE_OUT_VAL: out_val_ff <= reg_wdata[NOUT-1:0]; // RULE_18
          `DIOCE_PULSE:
          begin
            if (running_ff) // RULE_20
            begin
              pulse_mask_ff <= reg_wdata[NOUT-1:0]; // RULE_18
              pulse_cnt_ff <= pulse_len_ff;
            end
          end
          `DIOCE_PULSE_LEN: pulse_len_ff <= reg_wdata;
          `DIOCE_FILT_EN: filt_en_ff <= reg_wdata[NLINES-1:0];
          `DIOCE_INVERT: inv_ff <= reg_wdata[NLINES-1:0];
          `DIOCE_BOTH_EDGE: both_ff <= reg_wdata[NLINES-1:0];
          `DIOCE_ENC_EN: enc_en_ff <= reg_wdata[3:0]; // RULE_17
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-line threshold and limit writes
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      for (i = 0; i < NLINES; i = i + 1)
      begin
        thr_ff[i] <= `DIOCE_THR_RST;
        lim_ff[i] <= `DIOCE_LIM_RST;
      end
    end
    else if (wr_lines)
    begin
      // Zero is outside the legal range, so it is forced up to one
      if (reg_addr[7:3] == 5'h02) // Threshold bank
        thr_ff[widx] <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0]; // RULE_09
      if (reg_addr[7:3] == 5'h03) // Limit bank
        lim_ff[widx] <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0]; // RULE_12
    end
  end

  // ----------------------------------------------------------------
  // Per-line filter, edge counter and encoder
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NLINES; g = g + 1)
    begin : g_line
      wire is_enc;
      wire fin; // Counter input after optional filter
      wire edge_hit;
      wire [1:0] q_now;
      wire [1:0] q_old;
      wire step_up;
      wire step_dn;
      wire [31:0] delta;
      assign is_enc = enc_line(enc_en_ff, g[2:0]);
      // Encoder lines bypass the filter entirely
      assign fin = (filt_en_ff[g] && !is_enc) ? fout_ff[g] : inv_in[g]; // RULE_05
      assign edge_hit = (fin != prev_ff[g]) && (both_ff[g] || fin); // RULE_10
      // Quadrature decode lives on the even slot of each pair
      if (g % 2 == 0)
      begin : g_enc
        assign q_now = {inv_in[g+1], inv_in[g]};
        assign q_old = {prev_ff[g+1], prev_ff[g]};
        // Forward Gray order 00-01-11-10; a two-bit jump is ignored
        assign step_up = (q_old == 2'b00 && q_now == 2'b01) ||
                         (q_old == 2'b01 && q_now == 2'b11) ||
                         (q_old == 2'b11 && q_now == 2'b10) ||
                         (q_old == 2'b10 && q_now == 2'b00); // RULE_19
        assign step_dn = (q_now == 2'b00 && q_old == 2'b01) ||
                         (q_now == 2'b01 && q_old == 2'b11) ||
                         (q_now == 2'b11 && q_old == 2'b10) ||
                         (q_now == 2'b10 && q_old == 2'b00); // RULE_19
        // Decided here but raised by the odd slot, so each alarm bit has one driver
        assign dn_hit[g] = step_dn &&
                           (base_ff[g] - cnt_ff[g] + 32'h0000_0001 == {24'h0, lim_ff[g+1]});
      end
      else
      begin : g_noenc
        assign q_now = 2'b00;
        assign q_old = 2'b00;
        assign step_up = 1'b0;
        assign step_dn = 1'b0;
        assign dn_hit[g] = 1'b0;
      end
      assign delta = cnt_ff[g] - base_ff[g];

      always @(posedge core_clk)
      begin
        if (rst)
        begin
          fcnt_ff[g] <= 8'h00;
          fout_ff[g] <= 1'b0;
          prev_ff[g] <= 1'b0;
          cnt_ff[g] <= 32'h0000_0000;
          stamp_ff[g] <= 32'h0000_0000;
          base_ff[g] <= 32'h0000_0000;
          alarm_ff[g] <= 1'b0;
        end
        else if (start_ff)
        begin
          // Present levels become the assumed initial state
          fout_ff[g] <= inv_in[g]; // RULE_04
          fcnt_ff[g] <= inv_in[g] ? thr_ff[g] : 8'h00; // RULE_04
          prev_ff[g] <= inv_in[g];
          cnt_ff[g] <= 32'h0000_0000;
          base_ff[g] <= 32'h0000_0000;
          alarm_ff[g] <= 1'b0;
        end
        else
        begin
          // Reading the alarm word clears it; a new alarm wins
          if (reg_rd && reg_addr == `DIOCE_ALARM)
            alarm_ff[g] <= 1'b0;
          if (sample_en)
          begin
            // Saturating hysteresis filter
            if (inv_in[g] && fcnt_ff[g] < thr_ff[g])
              fcnt_ff[g] <= fcnt_ff[g] + 8'h01; // RULE_07
            else if (!inv_in[g] && fcnt_ff[g] != 8'h00)
              fcnt_ff[g] <= fcnt_ff[g] - 8'h01; // RULE_07
            if (inv_in[g] && fcnt_ff[g] + 8'h01 >= thr_ff[g])
              fout_ff[g] <= 1'b1; // RULE_08
            else if (!inv_in[g] && fcnt_ff[g] <= 8'h01)
              fout_ff[g] <= 1'b0; // RULE_08
            prev_ff[g] <= is_enc ? inv_in[g] : fin; // RULE_06
            if (is_enc && g % 2 == 0)
            begin
              // Encoder counter and two direction alarms
              if (step_up || step_dn)
              begin
                cnt_ff[g] <= step_up ? cnt_ff[g] + 32'h0000_0001
                                     : cnt_ff[g] - 32'h0000_0001; // RULE_15
                stamp_ff[g] <= time_ff;
              end
              if (step_up && delta + 32'h0000_0001 == {24'h0, lim_ff[g]})
              begin
                alarm_ff[g] <= 1'b1; // RULE_16
                base_ff[g] <= cnt_ff[g] + 32'h0000_0001;
              end
              else if (dn_hit[g])
                base_ff[g] <= cnt_ff[g] - 32'h0000_0001; // RULE_16
            end
            else if (is_enc)
            begin
              // Odd slot owns the down alarm bit of its pair
              if (dn_hit[g - g % 2])
                alarm_ff[g] <= 1'b1; // RULE_16
            end
            else if (edge_hit)
            begin
              cnt_ff[g] <= cnt_ff[g] + 32'h0000_0001; // RULE_10
              stamp_ff[g] <= time_ff; // RULE_13
              if (delta + 32'h0000_0001 == {24'h0, lim_ff[g]})
              begin
                alarm_ff[g] <= 1'b1; // RULE_12
                base_ff[g] <= cnt_ff[g] + 32'h0000_0001;
              end
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Alarm message: one pulse naming the lowest new alarm
  // ----------------------------------------------------------------
  reg [NLINES-1:0] alarm_seen_ff;
  reg [NLINES-1:0] alarm_new;
  reg [3:0] nxt_src;
  integer k;
  always @*
  begin
    alarm_new = alarm_ff & ~alarm_seen_ff;
    nxt_src = 4'h0;
    for (k = NLINES - 1; k >= 0; k = k - 1)
      if (alarm_new[k])
        nxt_src = k[3:0];
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      alarm_seen_ff <= {NLINES{1'b0}};
      alarm_pulse <= 1'b0;
      alarm_src <= 4'h0;
    end
    else
    begin
      alarm_seen_ff <= alarm_ff;
      alarm_pulse <= |alarm_new; // RULE_12
      if (|alarm_new)
        alarm_src <= nxt_src;
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr[7:3])
        5'h02: reg_rdata <= {24'h0, thr_ff[widx]};
        5'h03: reg_rdata <= {24'h0, lim_ff[widx]};
        5'h04: reg_rdata <= (widx[0] && enc_line(enc_en_ff, widx)) ?
                            cnt_ff[widx - 3'd1] : cnt_ff[widx];
        5'h05: reg_rdata <= stamp_ff[widx]; // RULE_13
        default:
        begin
          case (reg_addr)
            `DIOCE_CTRL: reg_rdata <= {31'h0, running_ff};
            `DIOCE_STATUS: reg_rdata <= {24'h0, fout_ff};
            `DIOCE_RATE: reg_rdata <= rate_ff;
            `DIOCE_OUT_EN: reg_rdata <= {26'h0, out_en_ff};
            `DIOCE_OUT_VAL: reg_rdata <= {26'h0, out_val_ff};
            `DIOCE_PULSE: reg_rdata <= {26'h0, pulse_mask_ff};
            `DIOCE_PULSE_LEN: reg_rdata <= pulse_len_ff;
            `DIOCE_FILT_EN: reg_rdata <= {24'h0, filt_en_ff};
            `DIOCE_INVERT: reg_rdata <= {24'h0, inv_ff};
            `DIOCE_BOTH_EDGE: reg_rdata <= {24'h0, both_ff};
            `DIOCE_ENC_EN: reg_rdata <= {28'h0, enc_en_ff};
            `DIOCE_ALARM: reg_rdata <= {24'h0, alarm_ff};
            `DIOCE_TIME: reg_rdata <= time_ff;
            `DIOCE_PINS: reg_rdata <= {24'h0, line_in}; // RULE_02
            default: reg_rdata <= 32'h0000_0000;
          endcase
        end
      endcase
    end
  end

endmodule // dioce_top

// ---- test/dioce_asserts.sv ----
// Assertion checker for the counter and encoder block ports
`timescale 1ns/1ps
`include "dioce_regs.vh"

module dioce_checker #(
  parameter NLINES = 8,
  parameter NOUT = 6
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Lines, alarm and run message
  input wire [NLINES-1:0] line_in,
  input wire [NLINES-1:0] line_out,
  input wire [NLINES-1:0] line_oe,
  input wire alarm_pulse,
  input wire [3:0] alarm_src,
  input wire run_done
);
  // ----
  // Command-side state
  // ----
  reg run_ff; // Run written, not stopped
  reg seen_ff; // Run reset sequence done
  wire ctl_wr = reg_wr && reg_addr == `DIOCE_CTRL;
  // Run flag built from commands only, so a design slip cannot hide there
  always @(posedge core_clk)
  begin
    if (rst || (ctl_wr && reg_wdata[`DIOCE_CTRL_STOP]))
    begin
      run_ff <= 1'b0;
      seen_ff <= 1'b0;
    end
    else if (ctl_wr && reg_wdata[`DIOCE_CTRL_RUN])
    begin
      run_ff <= 1'b1;
      seen_ff <= 1'b0;
    end
    else if (run_done)
      seen_ff <= 1'b1;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ----
  // Properties
  // ----
  sequence s_run_wr;
    ctl_wr && reg_wdata[`DIOCE_CTRL_RUN];
  endsequence
  sequence s_pulse_wr;
    !run_ff && reg_wr && reg_addr == `DIOCE_PULSE;
  endsequence
  property p_fixed_in;
    !line_oe[0] && !line_oe[NLINES-1] && !line_out[0] && !line_out[NLINES-1];
  endproperty
  a_fixed_in: assert property (p_fixed_in) else $error("input-only line driven");
  property p_oe_map;
    reg_wr && reg_addr == `DIOCE_OUT_EN |=> line_oe[NOUT:1] == $past(reg_wdata[NOUT-1:0]);
  endproperty
  a_oe_map: assert property (p_oe_map) else $error("enable map wrong");
  property p_out_val;
    !run_ff && reg_wr && reg_addr == `DIOCE_OUT_VAL
      |=> line_out[NOUT:1] == $past(reg_wdata[NOUT-1:0]);
  endproperty
  a_out_val: assert property (p_out_val) else $error("output level wrong");
  property p_pulse_ign;
    s_pulse_wr |=> $stable(line_out)[*3];
  endproperty
  a_pulse_ign: assert property (p_pulse_ign) else $error("pulse while stopped");
  property p_run_done;
    s_run_wr |-> ##2 run_done;
  endproperty
  a_run_done: assert property (p_run_done) else $error("run message late");
  property p_run_rd;
    reg_rd && reg_addr == `DIOCE_CTRL && (seen_ff || !run_ff) |=> reg_rdata[0] == $past(seen_ff);
  endproperty
  a_run_rd: assert property (p_run_rd) else $error("running bit wrong");
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_alarm_run;
    alarm_pulse |-> $past(run_ff, 2);
  endproperty
  a_alarm_run: assert property (p_alarm_run) else $error("alarm while stopped");
  property p_reset;
    disable iff (1'b0) rst |=> reg_rdata == 32'h0000_0000 && line_oe == 0 && !alarm_pulse;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs live in reset");
endmodule // dioce_checker

bind dioce_top dioce_checker #(.NLINES(NLINES), .NOUT(NOUT)) u_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in),
  .line_out(line_out), .line_oe(line_oe), .alarm_pulse(alarm_pulse),
  .alarm_src(alarm_src), .run_done(run_done)
);

// ---- test/dioce_line_model.sv ----
// Far-side line model: sensors on the eight lines
`timescale 1ns/1ps

module dioce_line_model (
  // From the block
  input wire [7:0] line_out,
  input wire [7:0] line_oe,
  // Sensor levels
  input wire [7:0] ext_lvl,
  // Wire level back
  output wire [7:0] line_in
);
  // A driven line shows the block's level, else the sensor's
  assign line_in = (line_oe & line_out) | (~line_oe & ext_lvl);
endmodule // dioce_line_model

// ---- test/digital_io_counter_encoder_bench.sv ----
// Self-checking bench for the counter and encoder block
`timescale 1ns/1ps
`include "dioce_regs.vh"

module digital_io_counter_encoder_bench;
  // ----
  // Signals
  // ----
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0000_0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] ext_lvl = 8'h00; // Sensor levels
  reg seen7 = 1'b0; // Alarm from line 8 seen
  reg [31:0] d; // Read data
  reg [31:0] c; // Encoder count
  wire [31:0] reg_rdata;
  wire [7:0] line_in;
  wire [7:0] line_out;
  wire [7:0] line_oe;
  wire alarm_pulse;
  wire [3:0] alarm_src;
  wire run_done;
  integer miscompares = 0;
  integer checked = 0;
  integer cyc = 0; // Timeout count
  integer n;
  always #5 core_clk = ~core_clk;
  dioce_top #(.NLINES(8), .NOUT(6)) DUT (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .alarm_pulse(alarm_pulse),
    .alarm_src(alarm_src), .run_done(run_done)
  );
  dioce_line_model u_lines (
    .line_out(line_out), .line_oe(line_oe), .ext_lvl(ext_lvl), .line_in(line_in)
  );
  // Alarm pulse stands one cycle only
  always @(posedge core_clk)
    if (alarm_pulse === 1'b1 && alarm_src === 4'h7)
      seen7 <= 1'b1;
  // Run needs about four hundred cycles
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      results;
    end
  end
  // ----
  // Tasks
  // ----
  task wr(input [7:0] a, input [31:0] v);
  begin
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  end
  endtask
  // Data stand from the cycle after the strobe until the next read
  task rd(input [7:0] a, output [31:0] v);
  begin
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    // End on an edge so the next stimulus lands at a rising edge
    @(posedge core_clk);
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task chk1(input got, input exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  end
  endtask
  // Each level held three sample ticks
  task togg(input integer b, input integer k);
    integer i;
  begin
    for (i = 0; i < k; i = i + 1)
    begin
      ext_lvl[b] <= ~ext_lvl[b];
      repeat (12) @(posedge core_clk);
    end
  end
  endtask
  task enc(input [1:0] v);
  begin
    ext_lvl[1:0] <= v;
    repeat (12) @(posedge core_clk);
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(`DIOCE_RATE, d);
    chk(d, `DIOCE_RATE_RST);
    rd(`DIOCE_LIM_BASE, d);
    chk(d, {24'h00_0000, `DIOCE_LIM_RST});
    rd(`DIOCE_PULSE_LEN, d);
    chk(d, `DIOCE_PULSE_LEN_RST);
    rd(8'hff, d);
    chk(d, 32'h0000_0000);
    wr(`DIOCE_THR_BASE + 8'h03, 32'h0000_00ff);
    rd(`DIOCE_THR_BASE + 8'h03, d);
    chk(d, 32'h0000_00ff);
    $display("register test done");
    wr(`DIOCE_OUT_EN, 32'h0000_003f);
    wr(`DIOCE_OUT_VAL, 32'h0000_0015);
    wr(`DIOCE_PULSE, 32'h0000_003f);
    repeat (5) @(posedge core_clk);
    #1;
    chk({24'h00_0000, line_oe}, 32'h0000_007e);
    chk({24'h00_0000, line_out}, 32'h0000_002a);
    wr(`DIOCE_OUT_EN, 32'h0000_0000);
    wr(`DIOCE_OUT_VAL, 32'h0000_0000);
    $display("output test done");
    wr(`DIOCE_RATE, 32'h0000_0004);
    wr(`DIOCE_FILT_EN, 32'h0000_0043);
    wr(`DIOCE_THR_BASE, 32'h0000_00ff);
    wr(`DIOCE_THR_BASE + 8'h01, 32'h0000_00ff);
    wr(`DIOCE_THR_BASE + 8'h06, 32'h0000_0003);
    wr(`DIOCE_LIM_BASE + 8'h07, 32'h0000_0002);
    wr(`DIOCE_INVERT, 32'h0000_0010);
    wr(`DIOCE_BOTH_EDGE, 32'h0000_0020);
    wr(`DIOCE_ENC_EN, 32'h0000_0001);
    ext_lvl <= 8'h40;
    wr(`DIOCE_CTRL, 32'h0000_0001);
    n = 0;
    while (run_done !== 1'b1 && n < 10)
    begin
      @(posedge core_clk);
      #1;
      n = n + 1;
    end
    chk1(run_done, 1'b1);
    rd(`DIOCE_STATUS, d);
    chk1(d[6], 1'b1);
    $display("run test done");
    togg(7, 3);
    togg(4, 3);
    togg(5, 3);
    rd(`DIOCE_CNT_BASE + 8'h07, d);
    chk(d, 32'h0000_0002);
    rd(`DIOCE_CNT_BASE + 8'h04, d);
    chk(d, 32'h0000_0001);
    rd(`DIOCE_CNT_BASE + 8'h05, d);
    chk(d, 32'h0000_0003);
    rd(`DIOCE_STAMP_BASE + 8'h07, d);
    chk1(d != 32'h0000_0000, 1'b1);
    chk1(seen7, 1'b1);
    ext_lvl[6] <= 1'b0;
    rd(`DIOCE_STATUS, d);
    chk1(d[6], 1'b1);
    repeat (30) @(posedge core_clk);
    rd(`DIOCE_STATUS, d);
    chk1(d[6], 1'b0);
    $display("counter test done");
    enc(2'b01);
    enc(2'b11);
    enc(2'b10);
    enc(2'b00);
    rd(`DIOCE_CNT_BASE, c);
    chk1(c === 32'h0000_0004 || c === 32'hffff_fffc, 1'b1);
    enc(2'b11);
    enc(2'b00);
    rd(`DIOCE_CNT_BASE, d);
    chk(d, c);
    enc(2'b10);
    enc(2'b11);
    enc(2'b01);
    enc(2'b00);
    rd(`DIOCE_CNT_BASE, d);
    chk(d, 32'h0000_0000);
    rd(`DIOCE_PINS, d);
    chk(d, 32'h0000_00b0);
    rd(`DIOCE_ALARM, d);
    chk(d, 32'h0000_00b3);
    rd(`DIOCE_ALARM, d);
    chk(d, 32'h0000_0000);
    $display("encoder test done");
    wr(`DIOCE_PULSE_LEN, 32'h0000_0008);
    wr(`DIOCE_OUT_EN, 32'h0000_003f);
    wr(`DIOCE_PULSE, 32'h0000_0001);
    @(posedge core_clk);
    #1;
    chk({24'h00_0000, line_out}, 32'h0000_0002);
    repeat (12) @(posedge core_clk);
    #1;
    chk({24'h00_0000, line_out}, 32'h0000_0000);
    wr(`DIOCE_CTRL, 32'h0000_0002);
    rd(`DIOCE_CTRL, d);
    chk1(d[0], 1'b0);
    $display("pulse test done");
    results;
  end
endmodule // digital_io_counter_encoder_bench
